//--- slpg_pkg.sv
// Purpose: shared constants and types for the status indicator generator
// Assumes: one 25 MHz clock, registers reached over APB
// Notes: times are kept in milliseconds, cycle counts derive from them
package slpg_pkg;

  // indicator modes that software may select per general output
  typedef enum logic [1:0] {
    SLPG_SOLUTION_AVAILABLE_MODE,
    SLPG_CARRIER_FIX_MODE,
    SLPG_CORRECTION_COUNT_MODE,
    SLPG_TRACKING_COUNT_MODE
  } slpg_mode_t;

  // receiver state delivered by internal status sources, same clock
  typedef struct packed {
    logic pvt_valid;      // a position solution is available
    logic rtk_float;      // carrier-phase solution, float
    logic rtk_fixed;      // carrier-phase solution, fixed
    logic rover;          // receiver runs as rover
    logic base_out;       // static base station emitting corrections
    logic diff_msg;       // pulse: correction message received
    logic [7:0] diff_count; // satellites in that message
    logic [7:0] track_count; // satellites in tracking
    logic card_present;   // storage card inserted
    logic card_mounted;   // storage card mounted
    logic log_activity;   // pulse: a logging write happened
  } slpg_rx_status_t;

  // register byte offsets
  localparam logic [7:0] SLPG_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SLPG_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SLPG_ADDR_COUNTS = 8'h08;

  // control field positions and values after reset
  localparam int SLPG_CTRL_MODE_A_LSB = 0;
  localparam int SLPG_CTRL_MODE_B_LSB = 2;
  localparam slpg_mode_t SLPG_MODE_A_RESET = SLPG_SOLUTION_AVAILABLE_MODE;
  localparam slpg_mode_t SLPG_MODE_B_RESET = SLPG_CARRIER_FIX_MODE;

  // clock and times
  localparam int SLPG_CLK_KHZ = 25000;
  localparam int SLPG_FAST_BLINKS_PER_S = 10;
  localparam int SLPG_BLINK_ON_MS = 150;
  localparam int SLPG_BLINK_OFF_MS = 250;
  localparam int SLPG_PAUSE_MS = 1000;
  localparam int SLPG_FLOAT_HALF_MS = 250;
  localparam int SLPG_LOG_PULSE_MS = 50;

  // derived cycle counts
  localparam int SLPG_FAST_HALF_CYC =
    (SLPG_CLK_KHZ * 1000) / (2 * SLPG_FAST_BLINKS_PER_S);
  localparam int SLPG_BLINK_ON_CYC = SLPG_BLINK_ON_MS * SLPG_CLK_KHZ;
  localparam int SLPG_BLINK_OFF_CYC = SLPG_BLINK_OFF_MS * SLPG_CLK_KHZ;
  localparam int SLPG_PAUSE_CYC = SLPG_PAUSE_MS * SLPG_CLK_KHZ;
  localparam int SLPG_FLOAT_HALF_CYC = SLPG_FLOAT_HALF_MS * SLPG_CLK_KHZ;
  localparam int SLPG_LOG_PULSE_CYC = SLPG_LOG_PULSE_MS * SLPG_CLK_KHZ;

  // largest burst length
  localparam logic [2:0] SLPG_MAX_BLINKS = 3'h5;

endpackage

//--- slpg_burst.sv
// Purpose: counted blink bursts, or fast continuous blink for zero
// Assumes: blinks input already mapped to 0..5
// Notes: burst length is latched only when a new burst starts
`timescale 1ns/1ps
module slpg_burst
#(
  parameter int unsigned ON_CYC = 16,
  parameter int unsigned OFF_CYC = 16,
  parameter int unsigned PAUSE_CYC = 64,
  parameter int unsigned FAST_CYC = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] blinks,
  output logic led
);
  import slpg_pkg::*;

  // burst phases
  typedef enum logic [1:0] {BL_ON, BL_GAP, BL_PAUSE} slpg_bl_t;

  slpg_bl_t state_q, state_d;
  logic [31:0] timer_q, timer_d; // cycles left in phase
  logic [2:0] n_q, n_d;          // blinks in current burst
  logic [2:0] done_q, done_d;    // blinks finished so far
  wire timer_end = (timer_q == 32'h0);
  wire [2:0] done_inc = done_q + 3'h1;
  // a fresh burst starts after the pause, or after each fast period
  wire load = timer_end && ((state_q == BL_PAUSE) ||
              (state_q == BL_GAP && n_q == 3'h0));
  wire [31:0] first_on = (blinks == 3'h0) ? FAST_CYC - 1 : ON_CYC - 1;

  // phase sequencing
  always_comb
  begin
    state_d = state_q;
    timer_d = timer_end ? timer_q : timer_q - 32'h1;
    n_d = n_q;
    done_d = done_q;
    if (load)
    begin
      n_d = blinks;
      done_d = 3'h0;
      state_d = BL_ON;
      timer_d = first_on;
    end
    else if (timer_end)
    begin
      case (state_q)
        BL_ON:
        begin
          done_d = done_inc;
          if (n_q == 3'h0)
          begin
            state_d = BL_GAP;
            timer_d = FAST_CYC - 1;
          end
          else if (done_inc == n_q)
          begin
            state_d = BL_PAUSE;
            timer_d = PAUSE_CYC - 1;
          end
          else
          begin
            state_d = BL_GAP;
            timer_d = OFF_CYC - 1;
          end
        end
        BL_GAP:
        begin
          state_d = BL_ON;
          timer_d = ON_CYC - 1;
        end
        default:
        begin
          state_d = BL_PAUSE;
        end
      endcase
    end
  end

  // phase registers; reset lands in an expired pause so a burst loads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= BL_PAUSE;
      timer_q <= 32'h0;
      n_q <= 3'h0;
      done_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      n_q <= n_d;
      done_q <= done_d;
    end
  end

  assign led = (state_q == BL_ON);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  burst_latch_a:
    assert property ($changed(n_q) |-> $past(load))
    else $error("burst length changed inside a burst");
  blink_count_a:
    assert property ((state_q == BL_GAP && n_q != 3'h0) |-> done_q < n_q)
    else $error("burst ran past its blink count");
  cover_burst_c: cover property (state_q == BL_ON && n_q == SLPG_MAX_BLINKS);
endmodule

//--- slpg_status_led.sv
// Purpose: drives two general indicators and the logging indicator
// Assumes: receiver status is synchronous to pclk, APB slave, no waits
// Notes: all indicator outputs are registered and active high
//
// Operation
// - indicator outputs are active high
// - two general outputs, mode set by command
// - output a defaults to solution-available mode
// - output b defaults to carrier-fix mode
// - solution mode: high while solution available
// - carrier mode: off, float blinks, fixed solid
// - correction mode: rover shows corrected satellites
// - correction mode: low before first message
// - zero count blinks ten times per second
// - nonzero count: one to five blinks, pause
// - tracking mode uses same burst mapping
// - tracking mode: solid while base outputs corrections
// - logging output low without mounted card
// - logging high when mounted, low pulses on activity
`timescale 1ns/1ps
module slpg_status_led
#(
  parameter int unsigned FAST_HALF_CYC = slpg_pkg::SLPG_FAST_HALF_CYC,
  parameter int unsigned BLINK_ON_CYC = slpg_pkg::SLPG_BLINK_ON_CYC,
  parameter int unsigned BLINK_OFF_CYC = slpg_pkg::SLPG_BLINK_OFF_CYC,
  parameter int unsigned PAUSE_CYC = slpg_pkg::SLPG_PAUSE_CYC,
  parameter int unsigned FLOAT_HALF_CYC = slpg_pkg::SLPG_FLOAT_HALF_CYC,
  parameter int unsigned LOG_PULSE_CYC = slpg_pkg::SLPG_LOG_PULSE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire slpg_pkg::slpg_rx_status_t rx_status,
  output logic general_indicator_a,
  output logic general_indicator_b,
  output logic logging_indicator
);
  import slpg_pkg::*;

  // apb state
  logic pready_q;            // access phase acknowledge
  logic pslverr_q;           // unmapped address flag
  logic [31:0] prdata_q;     // read data for the access phase

  // control and captured status
  slpg_mode_t mode_q [2];    // per general output
  logic diff_seen_q;         // a correction message has arrived
  logic [7:0] diff_count_q;  // satellites in the last message
  logic [31:0] float_tmr_q;  // float blink half period timer
  logic float_led_q;         // float blink phase
  logic [31:0] log_tmr_q;    // logging low pulse timer
  logic [1:0] ind_q;         // registered general outputs
  logic log_q;               // registered logging output
  logic ctrl_written_q;      // helper: control ever written

  // address decode; the setup cycle prepares the answer
  wire setup = psel && !penable;
  wire hit_ctrl = (paddr == SLPG_ADDR_CTRL);
  wire hit_status = (paddr == SLPG_ADDR_STATUS);
  wire hit_counts = (paddr == SLPG_ADDR_COUNTS);
  wire mapped = hit_ctrl || hit_status || hit_counts;
  // write commits only at the edge where pready is seen high
  wire wr_ctrl = psel && penable && pready_q && pwrite && hit_ctrl;

  // read views
  // status packs both lamps, the logging lamp, the card state and the
  // correction flag; the counts word shows the last message beside the
  // live tracking count, so software sees what the lamps encode
  wire [31:0] rd_ctrl = {28'h0, mode_q[1], mode_q[0]};
  wire card_ok = rx_status.card_present && rx_status.card_mounted;
  wire [31:0] rd_status = {26'h0, diff_seen_q, card_ok, log_q,
                           1'b0, ind_q};
  wire [31:0] rd_counts = {16'h0, rx_status.track_count, diff_count_q};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_status ? rd_status :
                       hit_counts ? rd_counts : 32'h0;

  // apb answer: one access cycle, no wait states
  // pready follows the setup cycle alone, which keeps the answer time
  // fixed; the cost is that read data is captured one cycle early
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // mode register, written by the indicator mode command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q[0] <= SLPG_MODE_A_RESET;
      mode_q[1] <= SLPG_MODE_B_RESET;
      ctrl_written_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // bits above the two mode fields are dropped, not stored
      // indicator mode command
      mode_q[0] <= slpg_mode_t'(pwdata[SLPG_CTRL_MODE_A_LSB +: 2]);
      mode_q[1] <= slpg_mode_t'(pwdata[SLPG_CTRL_MODE_B_LSB +: 2]);
      ctrl_written_q <= 1'b1;
    end
  end

  // correction message capture; the flag is never cleared by software
  // limitation: a stale count stays on show until the next message
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      diff_seen_q <= 1'b0;
      diff_count_q <= 8'h0;
    end
    else if (rx_status.diff_msg)
    begin
      diff_seen_q <= 1'b1;
      diff_count_q <= rx_status.diff_count;
    end
  end

  // float blink: free running, so both outputs blink in step
  // the phase is not restarted when a float solution first appears
  wire float_end = (float_tmr_q == 32'h0);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      float_tmr_q <= 32'h0;
      float_led_q <= 1'b0;
    end
    else
    begin
      float_tmr_q <= float_end ? FLOAT_HALF_CYC - 1 : float_tmr_q - 32'h1;
      float_led_q <= float_end ? !float_led_q : float_led_q;
    end
  end

  // per output: mode select, count mapping, burst generator
  // each output owns its generator, so two count modes keep own phase
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ind
    wire track = (mode_q[ch] == SLPG_TRACKING_COUNT_MODE);
    wire [7:0] cnt = track ? rx_status.track_count : diff_count_q;
    wire [8:0] cnt_up = {1'b0, cnt} + 9'h1;
    // pairs of counts per blink, capped at five
    wire [2:0] nb = (cnt >= 8'h9) ? SLPG_MAX_BLINKS : cnt_up[3:1];
    wire burst_led;
    logic led_d;

    slpg_burst #(
      .ON_CYC(BLINK_ON_CYC),
      .OFF_CYC(BLINK_OFF_CYC),
      .PAUSE_CYC(PAUSE_CYC),
      .FAST_CYC(FAST_HALF_CYC)
    ) u_burst (
      .pclk(pclk),
      .presetn(presetn),
      .blinks(nb),
      .led(burst_led)
    );

    // output choice by mode
    always_comb
    begin
      case (mode_q[ch])
        SLPG_SOLUTION_AVAILABLE_MODE: led_d = rx_status.pvt_valid;
        SLPG_CARRIER_FIX_MODE:
          led_d = rx_status.rtk_fixed ||
                  (rx_status.rtk_float && float_led_q);
        // dark until first message, rover only
        SLPG_CORRECTION_COUNT_MODE:
          led_d = rx_status.rover && diff_seen_q && burst_led;
        SLPG_TRACKING_COUNT_MODE:
          led_d = rx_status.base_out || burst_led;
        default: led_d = 1'b0;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        ind_q[ch] <= 1'b0;
      else
        ind_q[ch] <= led_d;
    end
  end

  // logging pulse: retriggered by each activity so bursts stay visible
  // a steady activity level holds the lamp dark until it ends
  wire log_busy = (log_tmr_q != 32'h0);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      log_tmr_q <= 32'h0;
      log_q <= 1'b0;
    end
    else
    begin
      log_tmr_q <= rx_status.log_activity ? LOG_PULSE_CYC :
                   log_busy ? log_tmr_q - 32'h1 : 32'h0;
      log_q <= card_ok && !rx_status.log_activity && !log_busy;
    end
  end

  // outputs straight from flip-flops
  // so the lamps never glitch while the mode decode settles
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign general_indicator_a = ind_q[0];
  assign general_indicator_b = ind_q[1];
  assign logging_indicator = log_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a:
    assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  mode_write_a:
    assert property ((mode_q[0] != $past(mode_q[0])) |-> $past(wr_ctrl))
    else $error("mode changed without a command");
  mode_default_a:
    assert property (!ctrl_written_q |->
      mode_q[0] == SLPG_SOLUTION_AVAILABLE_MODE &&
      mode_q[1] == SLPG_CARRIER_FIX_MODE)
    else $error("default modes wrong");
  solution_led_a:
    assert property (mode_q[0] == SLPG_SOLUTION_AVAILABLE_MODE
      |=> general_indicator_a == $past(rx_status.pvt_valid))
    else $error("solution indicator wrong");
  carrier_led_a:
    assert property ((mode_q[1] == SLPG_CARRIER_FIX_MODE &&
      !rx_status.rtk_float) |=>
      general_indicator_b == $past(rx_status.rtk_fixed))
    else $error("carrier indicator wrong");
  corr_dark_a:
    assert property ((mode_q[1] == SLPG_CORRECTION_COUNT_MODE &&
      !diff_seen_q) |=> !general_indicator_b)
    else $error("correction indicator lit before message");
  base_solid_a:
    assert property ((mode_q[0] == SLPG_TRACKING_COUNT_MODE &&
      rx_status.base_out) |=> general_indicator_a)
    else $error("base station indicator not solid");
  log_card_a:
    assert property (!card_ok |=> !logging_indicator)
    else $error("logging indicator lit without card");
  log_pulse_a:
    assert property ((card_ok && rx_status.log_activity) |=>
      !logging_indicator ##1 !logging_indicator)
    else $error("activity pulse missing");

  // further checks on the bus answer, refused or idle, and on steady lamp states
  fixed_solid_a:
    assert property ((mode_q[1] == SLPG_CARRIER_FIX_MODE &&
      rx_status.rtk_fixed) |=> general_indicator_b)
    else $error("fixed solution indicator not solid");
  corr_rover_a:
    assert property ((mode_q[1] == SLPG_CORRECTION_COUNT_MODE &&
      !rx_status.rover) |=> !general_indicator_b)
    else $error("correction indicator lit outside rover");
  log_relit_a:
    assert property ((card_ok && !rx_status.log_activity && !log_busy)
      |=> logging_indicator)
    else $error("logging indicator dark with idle card");
  err_answer_a:
    assert property ((setup && !mapped) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  idle_quiet_a:
    assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("apb answer outside access cycle");

  // scenarios worth seeing in coverage
  cover_mode_c: cover property (wr_ctrl);
  cover_msg_c: cover property (rx_status.diff_msg && !diff_seen_q);
  cover_log_c: cover property (card_ok && rx_status.log_activity);
  cover_err_c: cover property (pslverr);
endmodule

//--- slpg_led_model.sv
// Purpose: external lamps that count lit cycles and turn-on events
// Assumes: one lamp per indicator output, lit by a high level
// Notes: counters clear while clr is high; the bench sets each window
`timescale 1ns/1ps
module slpg_led_model
(
  input wire logic pclk,
  input wire logic clr,
  input wire logic [2:0] led,
  output logic [2:0][15:0] lit_cnt,
  output logic [2:0][15:0] rise_cnt
);
  // level at the previous edge, so each turn-on is seen once
  logic [2:0] prev_q;
  // sample all lamps on every rising edge
  always_ff @(posedge pclk)
  begin
    prev_q <= led;
    for (int i = 0; i < 3; i++)
    begin
      if (clr)
      begin
        lit_cnt[i] <= 16'h0000;
        rise_cnt[i] <= 16'h0000;
      end
      else
      begin
        lit_cnt[i] <= lit_cnt[i] + {15'h0000, led[i]};
        rise_cnt[i] <= rise_cnt[i] + {15'h0000, led[i] & ~prev_q[i]};
      end
    end
  end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for the status indicator generator
// Assumes: shortened timing knobs; lamps counted by the LED model
// Notes: windows span whole blink periods, so blink phase never matters
`timescale 1ns/1ps
module tb_top;
  import slpg_pkg::*;
  // shortened timing, shared by the design and the expectations
  localparam int FH = 4;
  localparam int ON = 3;
  localparam int OFF = 3;
  localparam int PS = 10;
  localparam int FL = 5;
  localparam int LG = 4;
  // longest burst plus margin, so a new count has taken hold
  localparam int SETTLE = 5 * (ON + OFF) - OFF + PS + 8;
  typedef struct packed {logic [7:0] cnt; logic [2:0] n;} slpg_row_t;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, clr, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic general_indicator_a, general_indicator_b, logging_indicator;
  slpg_rx_status_t st, nx;
  logic [2:0][15:0] lit_cnt, rise_cnt;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int n, per;
  // satellite count beside the burst length it must give
  slpg_row_t rows [11] = '{'{8'h00, 3'h0}, '{8'h01, 3'h1}, '{8'h02, 3'h1},
    '{8'h03, 3'h2}, '{8'h04, 3'h2}, '{8'h05, 3'h3}, '{8'h06, 3'h3},
    '{8'h07, 3'h4}, '{8'h08, 3'h4}, '{8'h09, 3'h5}, '{8'hff, 3'h5}};

  // 25 MHz clock
  always #20 pclk = ~pclk;

  slpg_status_led #(.FAST_HALF_CYC(FH), .BLINK_ON_CYC(ON),
    .BLINK_OFF_CYC(OFF), .PAUSE_CYC(PS), .FLOAT_HALF_CYC(FL),
    .LOG_PULSE_CYC(LG)) slpg_status_led_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_status(st),
    .general_indicator_a(general_indicator_a),
    .general_indicator_b(general_indicator_b),
    .logging_indicator(logging_indicator));

  slpg_led_model slpg_led_model_i (.pclk(pclk), .clr(clr),
    .led({logging_indicator, general_indicator_b, general_indicator_a}),
    .lit_cnt(lit_cnt), .rise_cnt(rise_cnt));

  // compare and count, report at once on a difference
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict, the only way the run ends
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one APB transfer; waits on pready, bounded, result in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 16)
    begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // hand the next receiver status to the design
  task go;
    @(posedge pclk);
    st <= nx;
  endtask

  task idle(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // clear the lamp counters, optionally pulse log activity, count win
  task meas(input int win, input logic pul);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    st.log_activity <= pul;
    @(posedge pclk);
    st.log_activity <= 1'b0;
    repeat (win - 1) @(posedge pclk);
    #1;
  endtask

  // a hang ends the run as a failure
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b0;
    nx = '0;
    st = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // table: a tracking, b correction, as rover, one message per row
    nx.rover = 1'b1;
    apb(1'b1, SLPG_ADDR_CTRL, 32'h0000000b);
    foreach (rows[i])
    begin
      nx.track_count = rows[i].cnt;
      nx.diff_count = rows[i].cnt;
      nx.diff_msg = 1'b1;
      go;
      nx.diff_msg = 1'b0;
      go;
      n = rows[i].n;
      per = (n == 0) ? 2 * FH : n * (ON + OFF) - OFF + PS;
      idle(SETTLE);
      meas(2 * per, 1'b0);
      for (int k = 0; k < 2; k++)
      begin
        chk(rise_cnt[k], (n == 0) ? 2 : 2 * n);
        chk(lit_cnt[k], (n == 0) ? 2 * FH : 2 * n * ON);
      end
      apb(1'b0, SLPG_ADDR_COUNTS, 32'h0);
      chk(rd, {16'h0, rows[i].cnt, rows[i].cnt});
    end
    // leaving rover blanks b; a base station lights a solid
    nx.rover = 1'b0;
    nx.base_out = 1'b1;
    go;
    idle(SETTLE);
    meas(40, 1'b0);
    chk(lit_cnt[1], 32'd0);
    chk(lit_cnt[0], 32'd40);
    // solution and carrier modes; float blinks, fixed wins
    apb(1'b1, SLPG_ADDR_CTRL, 32'h00000004);
    nx.rtk_float = 1'b1;
    go;
    meas(8 * FL, 1'b0);
    chk(lit_cnt[0], 32'd0);
    chk(rise_cnt[1], 32'd4);
    chk(lit_cnt[1], 4 * FL);
    chk(lit_cnt[2], 32'd0);
    nx.pvt_valid = 1'b1;
    nx.rtk_fixed = 1'b1;
    go;
    meas(40, 1'b0);
    chk(lit_cnt[0], 32'd40);
    chk(lit_cnt[1], 32'd40);
    nx.rtk_float = 1'b0;
    nx.rtk_fixed = 1'b0;
    nx.card_present = 1'b1;
    go;
    meas(40, 1'b0);
    chk(lit_cnt[1], 32'd0);
    chk(lit_cnt[2], 32'd0);
    // mounted card: lit, with one activity dip of pulse width plus one
    nx.card_mounted = 1'b1;
    go;
    meas(30, 1'b1);
    chk(lit_cnt[2], 30 - LG - 1);
    apb(1'b0, SLPG_ADDR_STATUS, 32'h0);
    chk({31'h0, rd[4]}, 32'h1);
    // upper control bits ignored, read-only and unmapped places
    apb(1'b1, SLPG_ADDR_CTRL, 32'hfffffff7);
    apb(1'b1, SLPG_ADDR_COUNTS, 32'hffffffff);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, SLPG_ADDR_CTRL, 32'h0);
    chk(rd, 32'h7);
    // reset in mid run: lamps dark, default modes back
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({general_indicator_a, general_indicator_b, logging_indicator},
      32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SLPG_ADDR_CTRL, 32'h0);
    chk(rd, 32'h4);
    nx.rover = 1'b1;
    nx.base_out = 1'b0;
    go;
    meas(20, 1'b0);
    chk(lit_cnt[0], 32'd20);
    chk(lit_cnt[1], 32'd0);
    // no correction message since reset keeps b dark
    apb(1'b1, SLPG_ADDR_CTRL, 32'h0000000b);
    idle(SETTLE);
    meas(40, 1'b0);
    chk(lit_cnt[1], 32'd0);
    tally_and_finish;
  end
endmodule
